// ### bench/bph_ctrl_monitor.sv
// Assertion checker for the packet handler control block.
`timescale 1ns/10ps
`include "bph_consts.svh"
module bph_ctrl_monitor #(
  parameter logic [15:0] STEP_CYC = 16'd125
) (
  input wire logic                i_clk,
  input wire logic                i_rst_n,
  input wire logic                i_ce,
  input wire bph_pkg::bph_cmd_t   i_cmd,
  input wire bph_pkg::bph_phy_t   i_phy,
  input wire bph_pkg::bph_state_t o_state,
  input wire logic                o_tx_go,
  input wire logic                o_rsp_valid,
  input wire logic [31:0]         o_rsp_data,
  input wire logic [2:0]          o_dio,
  input wire logic [31:0]         o_access_addr,
  input wire logic [23:0]         o_crc_seed
);
  import bph_pkg::*;
  logic [15:0] rx_cnt_q;
  wire take = i_ce && i_cmd.valid;
  wire q_take = take && (i_cmd.op == `BPH_OP_REG_READ || i_cmd.op == `BPH_OP_FRAME_STAT
                || i_cmd.op == `BPH_OP_BUFFER_STAT);
  wire tx_take = take && i_cmd.op == `BPH_OP_TRANSMIT;
  wire rx_ev = i_ce && o_state == BPH_RX && i_phy.rx_end && !i_cmd.valid;
  // The receive mode is remembered so that the end-of-packet behaviour can be judged.
  always_ff @(posedge i_clk or negedge i_rst_n)
    if (!i_rst_n) rx_cnt_q <= 16'h0000;
    else if (take && i_cmd.op == `BPH_OP_RECEIVE) rx_cnt_q <= i_cmd.arg[15:0];
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_tx_start;
    o_state == BPH_TX && o_tx_go;
  endsequence
  a_query_answer: assert property (q_take |=> o_rsp_valid)
    else $error("query without answer");
  a_answer_cause: assert property (o_rsp_valid && $past(i_ce) |-> $past(q_take))
    else $error("answer without query");
  a_answer_stands: assert property (!o_rsp_valid |-> $stable(o_rsp_data))
    else $error("answer data changed");
  a_tx_start: assert property (tx_take |=> s_tx_start)
    else $error("transmit did not start");
  a_go_pulse: assert property (o_tx_go && i_ce && !tx_take |=> !o_tx_go)
    else $error("start pulse too long");
  a_tx_return: assert property (i_ce && o_state == BPH_TX && i_phy.tx_end && !i_cmd.valid
    |=> o_state == BPH_IDLE)
    else $error("no standby after transmit");
  a_rx_single: assert property (rx_ev && rx_cnt_q == 16'h0000 |=> o_state != BPH_RX)
    else $error("single receive kept receiving");
  a_rx_cont: assert property (rx_ev && rx_cnt_q == `BPH_RX_CONTINUOUS |=> o_state != BPH_IDLE)
    else $error("continuous receive stopped");
  a_clear_all: assert property (take && i_cmd.op == `BPH_OP_FLAG_CLEAR && i_cmd.arg[4:0] == 5'h1F
    && o_state == BPH_IDLE && !(i_phy.tx_end || i_phy.rx_end || i_phy.sync_ok || i_phy.crc_bad)
    |=> o_dio == 3'h0)
    else $error("lines high after full clear");
  a_addr_msb: assert property (take && i_cmd.op == `BPH_OP_REG_WRITE && i_cmd.arg[23:8] == `BPH_ACCESS_ADDR_B3
    |=> o_access_addr[31:24] == $past(i_cmd.arg[7:0]))
    else $error("address top byte not written");
  a_seed_lsb: assert property (take && i_cmd.op == `BPH_OP_REG_WRITE && i_cmd.arg[23:8] == `BPH_CRC_SEED_LOW
    |=> o_crc_seed[7:0] == $past(i_cmd.arg[7:0]))
    else $error("seed low byte not written");
endmodule // bph_ctrl_monitor

bind bph_ctrl bph_ctrl_monitor #(.STEP_CYC(STEP_CYC)) u_bph_ctrl_monitor (.i_clk(i_clk), .i_rst_n(i_rst_n),
  .i_ce(i_ce), .i_cmd(i_cmd), .i_phy(i_phy), .o_state(o_state), .o_tx_go(o_tx_go), .o_rsp_valid(o_rsp_valid),
  .o_rsp_data(o_rsp_data), .o_dio(o_dio), .o_access_addr(o_access_addr), .o_crc_seed(o_crc_seed));

// ### bench/bph_ctrl_tb.sv
// Self-checking testbench for the packet handler control block.
`timescale 1ns/10ps
`include "bph_consts.svh"
module bph_ctrl_tb;
  import bph_pkg::*;
  logic        i_clk, i_rst_n, i_ce, tx_go, rsp_v;
  bph_cmd_t    cmd;
  bph_phy_t    phy;
  bph_state_t  st;
  logic [31:0] rsp, aa;
  logic [23:0] seed;
  logic [2:0]  dio;
  logic [7:0]  b [7];
  logic [7:0]  ln, of;
  logic [4:0]  r;
  int          n_errors, check_count, seed_v, n;
  localparam logic [15:0] ADR [7] = '{16'h09C7, 16'h09C8, 16'h09C9, 16'h09CF, 16'h09D0, 16'h09D1, 16'h09D2};

  bph_ctrl #(.STEP_CYC(16'd2)) u_bph_ctrl (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_cmd(cmd),
    .i_phy(phy), .o_state(st), .o_tx_go(tx_go), .o_rsp_valid(rsp_v), .o_rsp_data(rsp), .o_dio(dio),
    .o_access_addr(aa), .o_crc_seed(seed));
  bph_host_model u_bph_host_model (.i_clk(i_clk), .o_cmd(cmd));

  initial
  begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    if (n_errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic send(input logic [7:0] op, input logic [31:0] arg);
    u_bph_host_model.send(op, arg);
  endtask
  // Mask bits: tx end, rx end, sync found, sync failed, crc bad; each a one-cycle pulse.
  task automatic ev(input logic [4:0] m);
    @(negedge i_clk);
    {phy.crc_bad, phy.sync_fail, phy.sync_ok, phy.rx_end, phy.tx_end} = m;
    @(negedge i_clk);
    {phy.crc_bad, phy.sync_fail, phy.sync_ok, phy.rx_end, phy.tx_end} = 5'h00;
  endtask
  task automatic query(input logic [7:0] op, input logic [15:0] adr);
    send(op, {8'h00, adr, 8'h00});
    @(negedge i_clk);
  endtask
  task automatic wait_st(input bph_state_t s);
    n = 0;
    while (st !== s && n < 2000)
    begin
      @(negedge i_clk);
      n++;
    end
  endtask
  function automatic logic [7:0] exp_st2(logic sf, logic ld, logic [7:0] l, logic cb, logic ab, logic hd);
    return {1'b0, sf, ld && (l > 8'd37), cb, ab, hd, 1'b1, 1'b0};
  endfunction

  initial
  begin
    #200000;
    n_errors++;
    close_out();
  end

  initial
  begin
    seed_v = 32'h06860BAF;
    {i_rst_n, n_errors, check_count} = '0;
    i_ce = 1'b1;
    phy = '0;
    {phy.sync_en, phy.crc_en, phy.max_len} = {2'b11, 8'd37};
    repeat (16) @(negedge i_clk);
    i_rst_n = 1'b1;
    check({st, tx_go, rsp_v, dio}, 32'h0);
    for (int k = 0; k < 7; k++)
    begin
      b[k] = 8'($random(seed_v));
      send(`BPH_OP_REG_WRITE, {8'h00, ADR[k], b[k]});
    end
    check(aa, {b[3], b[4], b[5], b[6]});
    check(32'(seed), {8'h00, b[0], b[1], b[2]});
    for (int k = 0; k < 7; k++)
    begin
      query(`BPH_OP_REG_READ, ADR[k]);
      check(rsp, {24'h0, b[k]});
    end
    query(`BPH_OP_REG_READ, 16'h09CA);
    check(rsp, 32'h0);
    i_ce = 1'b0;
    send(`BPH_OP_TRANSMIT, 32'h0);
    check(32'(st), 32'(BPH_IDLE));
    i_ce = 1'b1;
    send(`BPH_OP_FLAG_ROUTE, {12'h000, 5'b10100, 5'b01010, 5'b00001, 5'h1F});
    send(`BPH_OP_TRANSMIT, 32'h0);
    check({st, tx_go}, {BPH_TX, 1'b1});
    repeat (60) @(negedge i_clk);
    check(32'(st), 32'(BPH_TX));
    ev(5'b00001);
    check({st, dio}, {BPH_IDLE, 3'b001});
    query(`BPH_OP_FRAME_STAT, 16'h0);
    check(32'(rsp[15:8]), 32'h01);
    send(`BPH_OP_FLAG_CLEAR, 32'h2);
    check(32'(dio), 32'h1);
    send(`BPH_OP_FLAG_CLEAR, 32'h1);
    check(32'(dio), 32'h0);
    send(`BPH_OP_TRANSMIT, 32'h3);
    wait_st(BPH_IDLE);
    check({st, dio}, {BPH_IDLE, 3'b100});
    send(`BPH_OP_FLAG_CLEAR, 32'h1F);
    repeat (4)
    begin
      r = 5'($random(seed_v));
      {ln, of} = 16'($random(seed_v));
      {phy.len_dyn, phy.len, phy.ofs} = {r[2], ln, of};
      {phy.abort, phy.hdr_ok} = {r[4], r[3]};
      send(`BPH_OP_RECEIVE, 32'h0);
      repeat (50) @(negedge i_clk);
      check(32'(st), 32'(BPH_RX));
      ev(r[0] ? 5'b01000 : 5'b00100);
      ev({r[1], 4'b0010});
      check({st, dio}, {BPH_IDLE, ~r[0], 2'b10});
      query(`BPH_OP_FRAME_STAT, 16'h0);
      check(32'(rsp[23:16]), 32'(exp_st2(r[0], r[2], ln, r[1], r[4], r[3])));
      check(32'(rsp[2:0]), r[0] ? 32'h0 : 32'h1);
      query(`BPH_OP_BUFFER_STAT, 16'h0);
      check(rsp, {16'h0, ln, of});
      send(`BPH_OP_FLAG_CLEAR, 32'h1F);
    end
    {phy.abort, phy.hdr_ok} = 2'b00;
    send(`BPH_OP_RECEIVE, 32'hFFFF);
    ev(5'b00010);
    check({st, dio}, {BPH_RX, 3'b010});
    u_bph_host_model.auto_respond(16'd35);
    ev(5'b00010);
    check(32'(st), 32'(BPH_RX));
    send(`BPH_OP_GO_IDLE, 32'h0);
    send(`BPH_OP_FLAG_CLEAR, 32'h1F);
    send(`BPH_OP_RECEIVE, 32'd5);
    wait_st(BPH_IDLE);
    check({st, dio}, {BPH_IDLE, 3'b100});
    send(`BPH_OP_FLAG_CLEAR, 32'h1F);
    send(`BPH_OP_RECEIVE, 32'd5);
    ev(5'b00100);
    repeat (60) @(negedge i_clk);
    check(32'(st), 32'(BPH_RX));
    ev(5'b00010);
    check(32'(st), 32'(BPH_IDLE));
    u_bph_host_model.auto_respond(16'd35);
    send(`BPH_OP_RECEIVE, 32'h0);
    ev(5'b00010);
    check(32'(st), 32'(BPH_GAP));
    n = 0;
    while (tx_go !== 1'b1 && n < 1000)
    begin
      @(negedge i_clk);
      n++;
    end
    // Two microseconds of gap at 125 cycles each, with a few cycles of pipeline slack.
    check(32'(n >= 240 && n <= 260), 32'h1);
    check(32'(st), 32'(BPH_TX));
    ev(5'b00001);
    send(`BPH_OP_RECEIVE, 32'h0);
    ev(5'b00010);
    send(`BPH_OP_GO_IDLE, 32'h0);
    n = 0;
    repeat (300)
    begin
      @(negedge i_clk);
      n += int'(tx_go === 1'b1);
    end
    check({st, 30'(n)}, {BPH_IDLE, 30'h0});
    send(`BPH_OP_RECEIVE, 32'h0);
    ev(5'b00010);
    check(32'(st), 32'(BPH_GAP));
    send(`BPH_OP_GO_IDLE, 32'h0);
    u_bph_host_model.auto_respond(16'd0);
    send(`BPH_OP_RECEIVE, 32'h0);
    ev(5'b00010);
    check(32'(st), 32'(BPH_IDLE));
    close_out();
  end
endmodule // bph_ctrl_tb

// ### bench/bph_host_model.sv
// Host model that issues commands to the packet handler control block.
`timescale 1ns/10ps
module bph_host_model (
  input  wire logic        i_clk,
  output bph_pkg::bph_cmd_t o_cmd
);
  import bph_pkg::*;
  initial o_cmd = '0;
  // Commands change at the falling edge only, so each is seen at exactly one rising edge.
  task automatic send(input logic [7:0] op, input logic [31:0] arg);
    @(negedge i_clk);
    o_cmd = '{valid: 1'b1, op: op, arg: arg};
    @(negedge i_clk);
    o_cmd = '0;
  endtask
  // The delay travels as one 16-bit field, most significant byte first on the wire.
  task automatic auto_respond(input logic [15:0] dly);
    send(8'h98, {16'h0000, dly[15:8], dly[7:0]});
  endtask
  // The host owns the protocol header inside the payload; this model sends no payload,
  // so the control block is never asked to build one.
  task automatic payload_header_note;
  endtask
endmodule // bph_host_model

// ### rtl/bph_consts.svh
// Constants for the low-energy packet handler control block.
`ifndef BPH_CONSTS_SVH
`define BPH_CONSTS_SVH

// ****************************************************************
// Register addresses
// ****************************************************************
`define BPH_CRC_SEED_HIGH   16'h09C7
`define BPH_CRC_SEED_MID    16'h09C8
`define BPH_CRC_SEED_LOW    16'h09C9
`define BPH_ACCESS_ADDR_B3  16'h09CF
`define BPH_ACCESS_ADDR_B2  16'h09D0
`define BPH_ACCESS_ADDR_B1  16'h09D1
`define BPH_ACCESS_ADDR_B0  16'h09D2

// ****************************************************************
// Command opcodes
// ****************************************************************
`define BPH_OP_GO_IDLE      8'h01
`define BPH_OP_TRANSMIT     8'h02
`define BPH_OP_RECEIVE      8'h03
`define BPH_OP_REG_WRITE    8'h04
`define BPH_OP_REG_READ     8'h05
`define BPH_OP_FLAG_CLEAR   8'h06
`define BPH_OP_FLAG_ROUTE   8'h07
`define BPH_OP_FRAME_STAT   8'h08
`define BPH_OP_BUFFER_STAT  8'h09
`define BPH_OP_AUTO_RESPOND 8'h98

// ****************************************************************
// Flag positions and status bits
// ****************************************************************
`define BPH_FLAG_TX_DONE    0
`define BPH_FLAG_RX_DONE    1
`define BPH_FLAG_SYNC       2
`define BPH_FLAG_CRC        3
`define BPH_FLAG_TIMEOUT    4
`define BPH_ST2_SYNC_FAIL   6
`define BPH_ST2_SIZE_OVER   5
`define BPH_ST2_CRC_ERR     4
`define BPH_ST2_ABORTED     3
`define BPH_ST2_HEADER      2
`define BPH_ST2_RX_DONE     1
`define BPH_ST2_BUSY        0
`define BPH_CORR_ERROR      8'h00
`define BPH_CORR_FIRST      8'h01
`define BPH_RX_CONTINUOUS   16'hFFFF

// ****************************************************************
// Timing
// ****************************************************************
`define BPH_CLK_NS          8
`define BPH_US_NS           1000
`define BPH_US_CYC          (`BPH_US_NS / `BPH_CLK_NS)
`define BPH_SWITCH_US       33

`endif

// ### rtl/bph_ctrl.sv
// Packet handler control: commands, registers, flags, timeouts and auto respond.
// Function
// - Access address kept in four bytes, most significant at lowest address.
// - CRC seed kept in three writable bytes, most significant at lowest address.
// - After transmit or its timeout, raise the flag and return to standby.
// - Transmit timeout runs only for a nonzero step count.
// - Transmit status bit 0 reports frame sent; upper bits read zero.
// - Receive count zero: no timeout, one packet, then standby.
// - Receive count all ones: stay receiving, flag each packet.
// - Other receive counts: timer, standby on expiry or packet; sync stops timer.
// - Receive done flag rises for every packet, good or bad.
// - Separate sync, CRC fail and timeout flags, each routable to DIO lines.
// - Status bit 6 marks sync failure when sync detection is enabled.
// - Status bit 5 marks dynamic length above configured maximum.
// - Status bit 4 marks CRC failure when CRC enabled; packet still kept.
// - Status carries abort, header seen, reception complete and busy bits.
// - Correlator code: zero on error, one for first correlator.
// - Flag clear resets exactly the flags selected in the mask.
// - Each DIO is the OR of its mapped flags.
// - Buffer query returns last length and start offset in the buffer.
// - Auto respond is opcode plus 16-bit delay, accepted only in standby.
// - After each reception, transmit after programmed delay minus 33 us.
// - Delay zero disarms; standby after reception cancels next auto transmit.
`timescale 1ns/10ps
`include "bph_consts.svh"

module bph_ctrl #(
  parameter logic [15:0] STEP_CYC = 16'd125
) (
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  input  wire logic              i_ce,
  input  wire bph_pkg::bph_cmd_t i_cmd,
  input  wire bph_pkg::bph_phy_t i_phy,
  output bph_pkg::bph_state_t    o_state,
  output logic                   o_tx_go,
  output logic                   o_rsp_valid,
  output logic [31:0]            o_rsp_data,
  output logic [2:0]             o_dio,
  output logic [31:0]            o_access_addr,
  output logic [23:0]            o_crc_seed
);
  import bph_pkg::*;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Reload value of the tick prescaler; the gap before an automatic
  // transmit counts microseconds, timeouts count programmed steps.
  function automatic logic [15:0] reload(input logic gap, input logic [1:0] base);
    logic [15:0] step;
    step = STEP_CYC << {base, 1'b0};
    reload = gap ? 16'(`BPH_US_CYC - 1) : 16'(step - 16'd1);
  endfunction

  // Byte register index, 7 marks an unmapped address.
  function automatic logic [2:0] reg_idx(input logic [15:0] addr);
    unique case (addr)
      `BPH_CRC_SEED_HIGH  : reg_idx = 3'd0;
      `BPH_CRC_SEED_MID   : reg_idx = 3'd1;
      `BPH_CRC_SEED_LOW   : reg_idx = 3'd2;
      `BPH_ACCESS_ADDR_B3 : reg_idx = 3'd3;
      `BPH_ACCESS_ADDR_B2 : reg_idx = 3'd4;
      `BPH_ACCESS_ADDR_B1 : reg_idx = 3'd5;
      `BPH_ACCESS_ADDR_B0 : reg_idx = 3'd6;
      default             : reg_idx = 3'd7;
    endcase
  endfunction

  bph_regs_t   q;
  bph_regs_t   d;
  logic [4:0]  set;
  logic [4:0]  clr;
  logic        tick;
  logic        expire;
  logic [15:0] count;
  logic [15:0] gap_us;
  logic [7:0]  rbyte;

  assign count  = i_cmd.arg[15:0];
  assign gap_us = (q.auto_us > 16'(`BPH_SWITCH_US)) ? 16'(q.auto_us - 16'(`BPH_SWITCH_US)) : 16'h0000;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    d      = q;
    d.tx_go = 1'b0;
    d.rsp_v = 1'b0;
    set    = 5'h00;
    clr    = 5'h00;
    tick   = 1'b0;
    expire = 1'b0;
    rbyte  = 8'h00;

    if (q.tmr_on)
    begin
      if (q.pre == 16'h0000)
      begin
        tick  = 1'b1;
        d.pre = reload(q.state == BPH_GAP, q.base);
      end
      else
      begin
        d.pre = q.pre - 16'd1;
      end
    end
    if (tick)
    begin
      if (q.tmr <= 16'd1)
      begin
        expire = 1'b1;
      end
      else
      begin
        d.tmr = q.tmr - 16'd1;
      end
    end

    unique case (q.state)
      BPH_IDLE :
      begin
        d.tmr_on = 1'b0;
      end
      BPH_TX :
      begin
        if (i_phy.tx_end)
        begin
          set[`BPH_FLAG_TX_DONE] = 1'b1;
          d.stat3                = 8'h01;
          d.stat2[`BPH_ST2_BUSY] = 1'b0;
          d.state                = BPH_IDLE;
          d.tmr_on               = 1'b0;
        end
        else if (expire)
        begin
          set[`BPH_FLAG_TIMEOUT] = 1'b1;
          d.stat2[`BPH_ST2_BUSY] = 1'b0;
          d.state                = BPH_IDLE;
          d.tmr_on               = 1'b0;
        end
        if (i_phy.abort)
        begin
          d.stat2[`BPH_ST2_ABORTED] = 1'b1;
        end
      end
      BPH_RX :
      begin
        if (i_phy.sync_ok)
        begin
          set[`BPH_FLAG_SYNC]    = 1'b1;
          d.stat4                = `BPH_CORR_FIRST;
          d.stat2[`BPH_ST2_BUSY] = 1'b1;
          d.tmr_on               = 1'b0;
        end
        if (i_phy.sync_fail)
        begin
          d.stat2[`BPH_ST2_SYNC_FAIL] = i_phy.sync_en;
          d.stat4                     = `BPH_CORR_ERROR;
        end
        if (i_phy.hdr_ok)
        begin
          d.stat2[`BPH_ST2_HEADER] = 1'b1;
        end
        if (i_phy.abort)
        begin
          d.stat2[`BPH_ST2_ABORTED] = 1'b1;
        end
        if (i_phy.rx_end)
        begin
          set[`BPH_FLAG_RX_DONE] = 1'b1;
          set[`BPH_FLAG_CRC]     = i_phy.crc_en & i_phy.crc_bad;
          d.stat2[`BPH_ST2_RX_DONE]   = 1'b1;
          d.stat2[`BPH_ST2_BUSY]      = 1'b0;
          d.stat2[`BPH_ST2_CRC_ERR]   = i_phy.crc_en & i_phy.crc_bad;
          d.stat2[`BPH_ST2_SIZE_OVER] = i_phy.len_dyn & (i_phy.len > i_phy.max_len);
          d.rx_len = i_phy.len;
          d.rx_ofs = i_phy.ofs;
          d.tmr_on = 1'b0;
          if (q.auto_us != 16'h0000)
          begin
            // Gap counts whole microseconds from the end of reception.
            d.state  = (gap_us == 16'h0000) ? BPH_TX : BPH_GAP;
            d.tx_go  = (gap_us == 16'h0000);
            d.tmr    = gap_us;
            d.tmr_on = (gap_us != 16'h0000);
            d.pre    = 16'(`BPH_US_CYC - 1);
            d.stat3  = 8'h00;
          end
          else if (!q.cont)
          begin
            d.state = BPH_IDLE;
          end
        end
        else if (expire)
        begin
          set[`BPH_FLAG_TIMEOUT] = 1'b1;
          d.state                = BPH_IDLE;
          d.tmr_on               = 1'b0;
        end
      end
      BPH_GAP :
      begin
        if (expire)
        begin
          d.state                = BPH_TX;
          d.tx_go                = 1'b1;
          d.tmr_on               = 1'b0;
          d.stat2[`BPH_ST2_BUSY] = 1'b1;
        end
      end
    endcase

    if (i_cmd.valid)
    begin
      unique case (i_cmd.op)
        `BPH_OP_GO_IDLE :
        begin
          // Leaving the gap drops only this pending response.
          d.state                = BPH_IDLE;
          d.tmr_on               = 1'b0;
          d.tx_go                = 1'b0;
          d.stat2[`BPH_ST2_BUSY] = 1'b0;
        end
        `BPH_OP_TRANSMIT :
        begin
          d.state                = BPH_TX;
          d.tx_go                = 1'b1;
          d.stat3                = 8'h00;
          d.stat2                = 8'h01;
          d.base                 = i_cmd.arg[17:16];
          d.tmr                  = count;
          d.tmr_on               = (count != 16'h0000);
          d.pre                  = reload(1'b0, i_cmd.arg[17:16]);
        end
        `BPH_OP_RECEIVE :
        begin
          d.state  = BPH_RX;
          d.tx_go  = 1'b0;
          d.stat2  = 8'h00;
          d.base   = i_cmd.arg[17:16];
          d.cont   = (count == `BPH_RX_CONTINUOUS);
          d.tmr    = count;
          d.tmr_on = (count != 16'h0000) && (count != `BPH_RX_CONTINUOUS);
          d.pre    = reload(1'b0, i_cmd.arg[17:16]);
        end
        `BPH_OP_AUTO_RESPOND :
        begin
          if (q.state == BPH_IDLE)
          begin
            d.auto_us = count;
          end
        end
        `BPH_OP_REG_WRITE :
        begin
          unique case (reg_idx(i_cmd.arg[23:8]))
            3'd0    : d.seed[23:16] = i_cmd.arg[7:0];
            3'd1    : d.seed[15:8]  = i_cmd.arg[7:0];
            3'd2    : d.seed[7:0]   = i_cmd.arg[7:0];
            3'd3    : d.aa[31:24]   = i_cmd.arg[7:0];
            3'd4    : d.aa[23:16]   = i_cmd.arg[7:0];
            3'd5    : d.aa[15:8]    = i_cmd.arg[7:0];
            3'd6    : d.aa[7:0]     = i_cmd.arg[7:0];
            default : d.aa          = q.aa;
          endcase
        end
        `BPH_OP_REG_READ :
        begin
          unique case (reg_idx(i_cmd.arg[23:8]))
            3'd0    : rbyte = q.seed[23:16];
            3'd1    : rbyte = q.seed[15:8];
            3'd2    : rbyte = q.seed[7:0];
            3'd3    : rbyte = q.aa[31:24];
            3'd4    : rbyte = q.aa[23:16];
            3'd5    : rbyte = q.aa[15:8];
            3'd6    : rbyte = q.aa[7:0];
            default : rbyte = 8'h00;
          endcase
          d.rsp_v = 1'b1;
          d.rsp   = {24'h000000, rbyte};
        end
        `BPH_OP_FLAG_CLEAR :
        begin
          clr = i_cmd.arg[4:0];
        end
        `BPH_OP_FLAG_ROUTE :
        begin
          d.irq_en  = i_cmd.arg[4:0];
          d.dio_map = i_cmd.arg[19:5];
        end
        `BPH_OP_FRAME_STAT :
        begin
          d.rsp_v = 1'b1;
          d.rsp   = {8'h00, q.stat2, q.stat3, q.stat4};
        end
        `BPH_OP_BUFFER_STAT :
        begin
          d.rsp_v = 1'b1;
          d.rsp   = {16'h0000, q.rx_len, q.rx_ofs};
        end
        default :
        begin
          d.rsp_v = 1'b0;
        end
      endcase
    end

    // A flag raised in the same cycle as its clear survives.
    d.flags = (q.flags & ~clr) | (set & q.irq_en);
    for (int k = 0; k < 3; k++)
    begin
      d.dio[k] = |(d.flags & d.dio_map[k*5 +: 5]);
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      q <= '0;
    end
    else if (i_ce)
    begin
      q <= d;
    end
  end

  assign o_state       = q.state;
  assign o_tx_go       = q.tx_go;
  assign o_rsp_valid   = q.rsp_v;
  assign o_rsp_data    = q.rsp;
  assign o_dio         = q.dio;
  assign o_access_addr = q.aa;
  assign o_crc_seed    = q.seed;

endmodule // bph_ctrl

// ### rtl/bph_pkg.sv
// Types shared by the packet handler control block.
package bph_pkg;

  typedef enum logic [1:0] {BPH_IDLE, BPH_TX, BPH_RX, BPH_GAP} bph_state_t;

  typedef struct packed {
    logic        valid;
    logic [7:0]  op;
    logic [31:0] arg;
  } bph_cmd_t;

  typedef struct packed {
    logic        tx_end;
    logic        sync_ok;
    logic        sync_fail;
    logic        hdr_ok;
    logic        rx_end;
    logic        abort;
    logic        crc_bad;
    logic        sync_en;
    logic        crc_en;
    logic        len_dyn;
    logic [7:0]  max_len;
    logic [7:0]  len;
    logic [7:0]  ofs;
  } bph_phy_t;

  typedef struct packed {
    bph_state_t  state;
    logic [31:0] aa;
    logic [23:0] seed;
    logic [4:0]  flags;
    logic [4:0]  irq_en;
    logic [14:0] dio_map;
    logic [15:0] tmr;
    logic        tmr_on;
    logic [15:0] pre;
    logic [1:0]  base;
    logic        cont;
    logic [15:0] auto_us;
    logic [7:0]  stat2;
    logic [7:0]  stat3;
    logic [7:0]  stat4;
    logic [7:0]  rx_len;
    logic [7:0]  rx_ofs;
    logic        tx_go;
    logic        rsp_v;
    logic [31:0] rsp;
    logic [2:0]  dio;
  } bph_regs_t;

endpackage
